// ===== watchdog_wakeup_reset_logic.v
`timescale 1ns/1ns
`include "wdt_map.vh"
module watchdog_wakeup_reset_logic #(
	parameter PINS = 8,
	parameter FAULT_DELAY = 16,
	parameter PC_W = 13
) (
	input wire aclk,
	input wire aresetn,
	input wire por_n,
	input wire [3:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [3:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire watchdog_tick,
	input wire watchdog_clear_instr,
	input wire halt_instr,
	input wire external_init_pin_n,
	input wire usb_reset,
	input wire [PINS-1:0] port_pins,
	input wire irq_request,
	input wire irq_enabled,
	input wire stack_full,
	output reg sleeping_r,
	output reg device_reset_r,
	output reg pc_sp_reset_r,
	output reg irq_vector_r,
	output reg resume_after_halt_r,
	output reg irq_pending_r,
	output reg [PC_W-1:0] pc_init_r,
	output reg [PINS-1:0] port_data_r,
	output reg [PINS-1:0] port_dir_r
);
	// power-on is the strongest reset and restores every por value
	wire por = ~por_n;
	// any reset of control, counters and sleep state; cause flags, status flags and port defaults wait for power-on
	wire sys_rst = ~aresetn | por;

	// block state; every flop runs on the rising edge of the system clock
	reg [7:0] wdt_ctrl_r; // key and period select
	reg [3:0] flags_r; // reset cause flags
	reg [PINS-1:0] pin_wake_enable_r; // per-pin wake enable
	reg watchdog_expiry_flag_r;
	reg powerdown_flag_r;
	reg [`CNT_W-1:0] cnt_r; // watchdog counter
	reg [15:0] fault_cnt_r; // key fault delay counter
	reg fault_armed_r;
	reg [PINS-1:0] pins_q_r; // previous pin level
	reg irq_at_halt_r; // request already set when halted

	// key decode; any pattern but the two codes counts as bad
	// a bad key also holds the counter until the fault reset lands
	wire [4:0] key = wdt_ctrl_r[`KEY_MSB:`KEY_LSB];
	wire key_bad = (key != `KEY_DISABLE) && (key != `KEY_ENABLE);
	wire wdt_on = (key == `KEY_ENABLE);

	// period decode: returns terminal count index
	// terminal count is one below the period, so the counter
	// overflows on exactly 2^N ticks of the slow oscillator
	function [`CNT_W-1:0] period_last;
		input [2:0] sel;
		begin
			case (sel)
				3'h0: period_last = `PERIOD_LAST_0;
				3'h1: period_last = `PERIOD_LAST_1;
				3'h2: period_last = `PERIOD_LAST_2;
				3'h3: period_last = `PERIOD_LAST_3;
				3'h4: period_last = `PERIOD_LAST_4;
				3'h5: period_last = `PERIOD_LAST_5;
				3'h6: period_last = `PERIOD_LAST_6;
				default: period_last = `PERIOD_LAST_7;
			endcase
		end
	endfunction

	// overflow only counts on a tick while the watchdog is enabled
	wire overflow = wdt_on && watchdog_tick &&
		(cnt_r == period_last(wdt_ctrl_r[`SEL_MSB:`SEL_LSB]));
	// fires once the delay counter has run up to the parameter
	wire fault_fire = fault_armed_r && (fault_cnt_r == FAULT_DELAY[15:0]);
	// per-pin falling edge, each qualified by its own wake enable
	wire [PINS-1:0] pin_fall_bits;
	genvar gi;
	generate
		for (gi = 0; gi < PINS; gi = gi + 1) begin : g_pin_fall
			assign pin_fall_bits[gi] = pins_q_r[gi] & ~port_pins[gi] & pin_wake_enable_r[gi];
		end
	endgenerate
	wire pin_fall = |pin_fall_bits;
	// reset pin is low active; a low level clears the counter
	wire pin_low = ~external_init_pin_n;

	// axi write: take address and data in either order, answer once both held
	// nothing new is taken while the response waits for bready, so at
	// most one write is ever in flight
	reg aw_held_r;
	reg w_held_r;
	reg [3:0] aw_addr_r;
	reg [31:0] w_data_r;
	reg [3:0] w_strb_r;
	assign s_axi_awready = ~aw_held_r & ~s_axi_bvalid;
	assign s_axi_wready = ~w_held_r & ~s_axi_bvalid;
	wire wr_fire = aw_held_r & w_held_r & ~s_axi_bvalid;
	wire wr_ctrl = wr_fire && (aw_addr_r == `ADDR_WDT_CTRL) && w_strb_r[0];
	wire wr_flags = wr_fire && (aw_addr_r == `ADDR_RST_FLAGS) && w_strb_r[0];
	wire wr_wake = wr_fire && (aw_addr_r == `ADDR_WAKE_CTRL) && w_strb_r[0];
	wire wr_known = (aw_addr_r == `ADDR_WDT_CTRL) || (aw_addr_r == `ADDR_RST_FLAGS) ||
		(aw_addr_r == `ADDR_WAKE_CTRL) || (aw_addr_r == `ADDR_CPU_STATUS);

	// write channel holding and response
	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_r <= 1'b0;
			w_held_r <= 1'b0;
			aw_addr_r <= 4'h0;
			w_data_r <= 32'h00000000;
			w_strb_r <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RESP_OKAY;
		end else begin
			// take the address when offered
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_r <= 1'b1;
				aw_addr_r <= s_axi_awaddr;
			end
			// take the data and strobes when offered
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_r <= 1'b1;
				w_data_r <= s_axi_wdata;
				w_strb_r <= s_axi_wstrb;
			end
			// both halves held: commit and answer
			if (wr_fire) begin
				aw_held_r <= 1'b0;
				w_held_r <= 1'b0;
				s_axi_bvalid <= 1'b1;
				// status register is read only, so writes there are refused too
				s_axi_bresp <= (wr_known && aw_addr_r != `ADDR_CPU_STATUS) ? `RESP_OKAY : `RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				// response accepted by the master
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// axi read: one cycle to answer, data registered
	// the address is decoded straight off the bus, so no address register
	// is needed; arready stays low while the data waits for rready
	assign s_axi_arready = ~s_axi_rvalid;
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= `RESP_OKAY;
			case (s_axi_araddr)
				`ADDR_WDT_CTRL: s_axi_rdata <= {24'h000000, wdt_ctrl_r};
				`ADDR_RST_FLAGS: s_axi_rdata <= {28'h0000000, flags_r};
				`ADDR_WAKE_CTRL: s_axi_rdata <= {{(32-PINS){1'b0}}, pin_wake_enable_r};
				`ADDR_CPU_STATUS: s_axi_rdata <= {30'h00000000, powerdown_flag_r, watchdog_expiry_flag_r};
				// unmapped offsets read zero with an error response
				default: begin
					s_axi_rdata <= 32'h00000000;
					s_axi_rresp <= `RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// control register and wake enables; a watchdog warm reset keeps them
	// a key fault is a full reset, so the key and wake enables return
	// to their power-on values and the watchdog restarts enabled
	always @(posedge aclk) begin
		if (sys_rst || fault_fire) begin
			wdt_ctrl_r <= `WDT_CTRL_POR;
			pin_wake_enable_r <= {PINS{1'b0}};
		end else begin
			if (wr_ctrl)
				wdt_ctrl_r <= w_data_r[7:0];
			if (wr_wake)
				pin_wake_enable_r <= w_data_r[PINS-1:0];
		end
	end

	// key fault flag: set wins over a software clear, cleared only by power-on or by writing zero
	// bits 3..1 are set by circuits outside this block; here they are kept and cleared by writes of zero
	always @(posedge aclk) begin
		if (por) begin
			flags_r <= 4'h0;
		end else if (fault_fire) begin
			flags_r[`BIT_KEY_FAULT] <= 1'b1;
		end else if (wr_flags) begin
			// other bits belong to outside circuits; writes of zero clear them only
			flags_r <= flags_r & w_data_r[3:0];
		end
	end

	// key fault delay: counts while the key stays bad, then fires once
	// the armed bit keeps a stale count from matching on the first bad
	// cycle; a good key before the count reaches the delay abandons the pending fault
	always @(posedge aclk) begin
		if (sys_rst || fault_fire || !key_bad) begin
			fault_cnt_r <= 16'h0000;
			fault_armed_r <= key_bad & ~sys_rst & ~fault_fire;
		end else begin
			fault_armed_r <= 1'b1;
			fault_cnt_r <= fault_cnt_r + 16'h0001;
		end
	end

	// watchdog counter: cleared by fault, clear instruction, halt or a low pin
	// a bad key holds it at zero so a stuck key cannot also overflow;
	// after a halt it resumes only while the key says enabled
	always @(posedge aclk) begin
		if (sys_rst || key_bad || watchdog_clear_instr || halt_instr || pin_low || overflow) begin
			cnt_r <= {`CNT_W{1'b0}};
		end else if (wdt_on && watchdog_tick) begin
			cnt_r <= cnt_r + 18'h00001;
		end
	end

	// expiry and powerdown flags; power-on clears, pin reset keeps them
	// overflow outranks halt and clear in one cycle, so software can
	// tell afterwards, until the next halt clears it, that an expiry happened
	always @(posedge aclk) begin
		if (por) begin
			watchdog_expiry_flag_r <= 1'b0;
			powerdown_flag_r <= 1'b0;
		end else if (overflow) begin
			watchdog_expiry_flag_r <= 1'b1;
			if (sleeping_r)
				powerdown_flag_r <= 1'b1;
		end else if (halt_instr) begin
			powerdown_flag_r <= 1'b1;
			watchdog_expiry_flag_r <= 1'b0;
		end else if (watchdog_clear_instr) begin
			powerdown_flag_r <= 1'b0;
		end
	end

	// sleep state and wake decision
	// the pulse outputs fall every edge unless a wake source, or an awake overflow, key fault or usb reset, sets them
	wire irq_wake = irq_request & ~irq_at_halt_r;
	always @(posedge aclk) begin
		if (sys_rst) begin
			sleeping_r <= 1'b0;
			irq_at_halt_r <= 1'b0;
			pins_q_r <= {PINS{1'b1}};
			device_reset_r <= 1'b0;
			pc_sp_reset_r <= 1'b0;
			irq_vector_r <= 1'b0;
			resume_after_halt_r <= 1'b0;
			irq_pending_r <= 1'b0;
		end else begin
			pins_q_r <= port_pins;
			device_reset_r <= 1'b0;
			pc_sp_reset_r <= 1'b0;
			irq_vector_r <= 1'b0;
			resume_after_halt_r <= 1'b0;
			if (!irq_request)
				irq_at_halt_r <= 1'b0;
			// pending request stays until it can be serviced
			if (irq_pending_r && irq_enabled && !stack_full)
				irq_pending_r <= 1'b0;
			// entering sleep: remember a request that is already raised
			if (halt_instr && !sleeping_r) begin
				sleeping_r <= 1'b1;
				irq_at_halt_r <= irq_request;
			end else if (sleeping_r) begin
				// wake sources in priority order: resets first, then overflow,
				// pin edge and interrupt; resets wake with a full reset
				if (pin_low || usb_reset || fault_fire) begin
					sleeping_r <= 1'b0;
					device_reset_r <= 1'b1;
				end else if (overflow) begin
					sleeping_r <= 1'b0;
					pc_sp_reset_r <= 1'b1;
				end else if (pin_fall) begin
					// a pin edge resumes after the halt
					sleeping_r <= 1'b0;
					resume_after_halt_r <= 1'b1;
				end else if (irq_wake) begin
					// interrupt: vector now, or resume and keep it waiting
					sleeping_r <= 1'b0;
					if (irq_enabled && !stack_full) begin
						irq_vector_r <= 1'b1;
					end else begin
						resume_after_halt_r <= 1'b1;
						irq_pending_r <= 1'b1;
					end
				end
			end else if (overflow || fault_fire || usb_reset) begin
				// awake: overflow, key fault or usb reset reset the device
				device_reset_r <= 1'b1;
			end
		end
	end

	// power-on defaults for program counter and ports
	// these hold until the next power-on; an ordinary reset keeps them,
	// so a pin reset leaves the port setup at its power-on values
	always @(posedge aclk) begin
		if (por) begin
			pc_init_r <= `PC_RESET;
			port_data_r <= {PINS{1'b1}};
			port_dir_r <= {PINS{1'b1}};
		end
	end
endmodule

// ===== watchdog_wakeup_reset_logic_bench.sv
`timescale 1ns/1ns
`include "wdt_map.vh"
module watchdog_wakeup_reset_logic_bench;
	logic aclk = 0, aresetn = 0, por_n = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0, watchdog_tick = 0, watchdog_clear_instr = 0, halt_instr = 0;
	logic external_init_pin_n = 1, usb_reset = 0, irq_request = 0, irq_enabled = 0, stack_full = 0;
	logic [3:0] s_axi_awaddr = 0, s_axi_wstrb = 4'hf, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0;
	logic [7:0] port_pins = 8'hff;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, sleeping_r, device_reset_r;
	wire pc_sp_reset_r, irq_vector_r, resume_after_halt_r, irq_pending_r;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	wire [12:0] pc_init_r;
	wire [7:0] port_data_r, port_dir_r;
	int fails = 0, cmp_count = 0, n_rst = 0, n_pc = 0, n_res = 0, n_vec = 0, e;
	logic [31:0] d;
	logic [1:0] r, rr;
	// register rows: address, data written, read back, write response
	logic [69:0] rows [4] = '{{4'h0, 32'h51, 32'h51, 2'h0}, {4'h8, 32'h0f, 32'h0f, 2'h0},
		{4'hc, 32'hff, 32'h0, 2'h2}, {4'h4, 32'hff, 32'h0, 2'h0}};
	// small fault delay keeps the run short
	watchdog_wakeup_reset_logic #(.FAULT_DELAY(4)) dut (
		.aclk(aclk),
		.aresetn(aresetn),
		.por_n(por_n),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.watchdog_tick(watchdog_tick),
		.watchdog_clear_instr(watchdog_clear_instr),
		.halt_instr(halt_instr),
		.external_init_pin_n(external_init_pin_n),
		.usb_reset(usb_reset),
		.port_pins(port_pins),
		.irq_request(irq_request),
		.irq_enabled(irq_enabled),
		.stack_full(stack_full),
		.sleeping_r(sleeping_r),
		.device_reset_r(device_reset_r),
		.pc_sp_reset_r(pc_sp_reset_r),
		.irq_vector_r(irq_vector_r),
		.resume_after_halt_r(resume_after_halt_r),
		.irq_pending_r(irq_pending_r),
		.pc_init_r(pc_init_r),
		.port_data_r(port_data_r),
		.port_dir_r(port_dir_r)
	);
	initial forever #5 aclk = ~aclk;
	// count single-cycle pulses so tests compare totals
	always @(posedge aclk) begin
		n_rst <= n_rst + device_reset_r;
		n_pc <= n_pc + pc_sp_reset_r;
		n_res <= n_res + resume_after_halt_r;
		n_vec <= n_vec + irq_vector_r;
	end
	task chk(input [31:0] s, input [31:0] x);
		cmp_count++;
		if (s !== x) begin
			fails++;
			$display("CHECK FAILED %0t got %h exp %h", $time, s, x);
		end
	endtask
	task complete_run;
		if (fails == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// each channel is released only at the edge that takes it
	task wr(input [3:0] a, input [31:0] v, output [1:0] rs);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while ((s_axi_awvalid && !s_axi_awready) || (s_axi_wvalid && !s_axi_wready));
		while (!s_axi_bvalid) @(posedge aclk);
		rs = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task rd(input [3:0] a, output [31:0] v);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (!s_axi_rvalid);
		v = s_axi_rdata;
		rr = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	task rchk(input [3:0] a, input [31:0] x);
		rd(a, d);
		chk(d, x);
	endtask
	// one-cycle pulse on halt, clear or usb reset
	task op(input [2:0] k);
		@(posedge aclk) {halt_instr, watchdog_clear_instr, usb_reset} <= k;
		@(posedge aclk) {halt_instr, watchdog_clear_instr, usb_reset} <= 3'h0;
	endtask
	task tick(input int n);
		repeat (n) begin
			@(posedge aclk) watchdog_tick <= 1'b1;
			@(posedge aclk) watchdog_tick <= 1'b0;
		end
	endtask
	task cyc(input int n);
		repeat (n) @(posedge aclk);
	endtask
	// hang guard, well beyond the expected run
	initial begin
		#400000;
		fails++;
		complete_run;
	end
	initial begin
		cyc(6);
		por_n <= 1'b1;
		aresetn <= 1'b1;
		cyc(2);
		chk(pc_init_r, 0);
		chk({port_data_r, port_dir_r}, 16'hffff);
		rchk(`ADDR_WDT_CTRL, `WDT_CTRL_POR);
		foreach (rows[i]) begin
			wr(rows[i][69:66], rows[i][65:34], r);
			chk(r, rows[i][1:0]);
			rchk(rows[i][69:66], rows[i][33:2]);
			chk(rr, 2'h0);
		end
		// last tick short of the period must not expire
		for (int s = 0; s < 3; s++) begin
			wr(`ADDR_WDT_CTRL, 32'h50 | s, r);
			op(3'h2);
			e = n_rst + 1;
			tick((256 << (2 * s)) - 1);
			cyc(3);
			chk(n_rst, e - 1);
			tick(1);
			cyc(3);
			chk(n_rst, e);
		end
		rchk(`ADDR_CPU_STATUS, 32'h1);
		wr(`ADDR_WDT_CTRL, 32'ha8, r);
		tick(300);
		cyc(3);
		chk(n_rst, e);
		wr(`ADDR_WDT_CTRL, 32'h0, r);
		cyc(10);
		chk(n_rst, e + 1);
		rchk(`ADDR_RST_FLAGS, 32'h1);
		rchk(`ADDR_WDT_CTRL, `WDT_CTRL_POR);
		wr(`ADDR_RST_FLAGS, 32'hff, r);
		rchk(`ADDR_RST_FLAGS, 32'h1);
		wr(`ADDR_RST_FLAGS, 32'h0, r);
		rchk(`ADDR_RST_FLAGS, 32'h0);
		// a low reset pin restarts the count: 400 ticks, no overflow
		wr(`ADDR_WDT_CTRL, 32'h50, r);
		tick(200);
		@(posedge aclk) external_init_pin_n <= 1'b0;
		@(posedge aclk) external_init_pin_n <= 1'b1;
		tick(200);
		cyc(3);
		chk(n_rst, e + 1);
		// halt, then overflow while asleep
		op(3'h4);
		cyc(2);
		chk(sleeping_r, 1);
		rchk(`ADDR_CPU_STATUS, 32'h2);
		tick(255);
		cyc(3);
		chk(n_pc, 0);
		tick(1);
		cyc(3);
		chk(n_pc, 1);
		rchk(`ADDR_CPU_STATUS, 32'h3);
		op(3'h2);
		rchk(`ADDR_CPU_STATUS, 32'h1);
		// enabled pin falling edge wakes; the key fault cleared the enables, so they are written again first
		wr(`ADDR_WAKE_CTRL, 32'h0f, r);
		op(3'h4);
		@(posedge aclk) port_pins <= 8'hfe;
		cyc(3);
		chk(n_res, 1);
		chk(sleeping_r, 0);
		port_pins <= 8'hff;
		// request already raised at halt is no wake source
		irq_enabled <= 1'b1;
		irq_request <= 1'b1;
		op(3'h4);
		cyc(4);
		chk(sleeping_r, 1);
		op(3'h1);
		cyc(3);
		chk(n_rst, e + 2);
		irq_request <= 1'b0;
		op(3'h4);
		@(posedge aclk) irq_request <= 1'b1;
		cyc(3);
		chk(n_vec, 1);
		irq_request <= 1'b0;
		irq_enabled <= 1'b0;
		op(3'h4);
		@(posedge aclk) irq_request <= 1'b1;
		cyc(3);
		chk(n_res, 2);
		chk(irq_pending_r, 1);
		// the waiting request stays while the stack is full
		irq_enabled <= 1'b1;
		stack_full <= 1'b1;
		cyc(3);
		chk(irq_pending_r, 1);
		stack_full <= 1'b0;
		cyc(3);
		chk(irq_pending_r, 0);
		// warm reset mid-run restores control, keeps the status flags
		aresetn <= 1'b0;
		cyc(2);
		aresetn <= 1'b1;
		cyc(2);
		rchk(`ADDR_WDT_CTRL, `WDT_CTRL_POR);
		rchk(`ADDR_WAKE_CTRL, 32'h0);
		rchk(`ADDR_CPU_STATUS, 32'h2);
		complete_run;
	end
endmodule

// ===== wdt_checks_props.sv
`timescale 1ns/1ns
// pin-level relations of the watchdog and wake logic
module wdt_checks (
	input wire aclk,
	input wire aresetn,
	input wire por_n,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire s_axi_rvalid,
	input wire s_axi_rready,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire halt_instr,
	input wire usb_reset,
	input wire external_init_pin_n,
	input wire sleeping_r,
	input wire device_reset_r,
	input wire pc_sp_reset_r,
	input wire irq_vector_r,
	input wire resume_after_halt_r
);
	default clocking @(posedge aclk); endclocking
	// either reset drops every watch
	default disable iff (!aresetn || !por_n);
	// read address accepted
	sequence s_ar_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	// a halt with no competing reset source
	sequence s_clean_halt;
		halt_instr && !sleeping_r && external_init_pin_n && !usb_reset;
	endsequence
	a_read_answer: assert property (s_ar_taken |=> s_axi_rvalid)
		else $error("read answer late");
	a_rvalid_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
		else $error("read data dropped early");
	a_bvalid_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped early");
	a_halt_sleeps: assert property (s_clean_halt |=> sleeping_r)
		else $error("halt did not enter sleep");
	a_reset_pulse: assert property (device_reset_r |=> !device_reset_r)
		else $error("device reset longer than one cycle");
	a_pcsp_asleep: assert property (pc_sp_reset_r |-> $past(sleeping_r))
		else $error("pc reset while awake");
	a_resume_asleep: assert property (resume_after_halt_r |-> $past(sleeping_r))
		else $error("resume without sleep");
	a_vector_asleep: assert property (irq_vector_r |-> $past(sleeping_r))
		else $error("vector without sleep");
endmodule
bind watchdog_wakeup_reset_logic wdt_checks chk_u (.aclk, .aresetn, .por_n, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rvalid, .s_axi_rready, .s_axi_bvalid, .s_axi_bready, .halt_instr, .usb_reset, .external_init_pin_n,
	.sleeping_r, .device_reset_r, .pc_sp_reset_r, .irq_vector_r, .resume_after_halt_r);

// ===== wdt_map.vh
`ifndef WDT_MAP_VH
`define WDT_MAP_VH
// register byte addresses on the axi4-lite bus
`define ADDR_WDT_CTRL 4'h0
`define ADDR_RST_FLAGS 4'h4
`define ADDR_WAKE_CTRL 4'h8
`define ADDR_CPU_STATUS 4'hc
// watchdog control fields and values
`define KEY_MSB 7
`define KEY_LSB 3
`define SEL_MSB 2
`define SEL_LSB 0
`define KEY_DISABLE 5'h15
`define KEY_ENABLE 5'h0a
`define WDT_CTRL_POR 8'h53
// reset cause flag bit positions
`define BIT_CTRL_FAULT 3
`define BIT_LOW_SUPPLY 2
`define BIT_VOLT_FAULT 1
`define BIT_KEY_FAULT 0
// status bit positions
`define BIT_EXPIRY 0
`define BIT_POWERDOWN 1
// axi responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
// counter width for 2^18 periods
`define CNT_W 18
// terminal counts of the eight time-out periods, one below each power of two
`define PERIOD_LAST_0 18'h000ff
`define PERIOD_LAST_1 18'h003ff
`define PERIOD_LAST_2 18'h00fff
`define PERIOD_LAST_3 18'h03fff
`define PERIOD_LAST_4 18'h07fff
`define PERIOD_LAST_5 18'h0ffff
`define PERIOD_LAST_6 18'h1ffff
`define PERIOD_LAST_7 18'h3ffff
`define PC_RESET 13'h0000
`endif
